// ### rtl/mru_pkg.sv
// Purpose: shared constants and types for the multiply/rotate/repeat unit
// Assumes: AXI4-Lite slave with 32-bit data, byte addresses on 8 bits
// Notes:   command codes are written by software into the command register
package mru_pkg;
    localparam int DW     = 32;
    localparam int AW     = 8;
    localparam int REPEAT_COUNTER_W = 16;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [AW-1:0] ADDR_CMD   = 8'h00;
    localparam logic [AW-1:0] ADDR_ACC   = 8'h04;
    localparam logic [AW-1:0] ADDR_XT    = 8'h08;
    localparam logic [AW-1:0] ADDR_P     = 8'h0C;
    localparam logic [AW-1:0] ADDR_OPND  = 8'h10;
    localparam logic [AW-1:0] ADDR_FLAGS = 8'h14;
    localparam logic [AW-1:0] ADDR_REPEAT_COUNTER  = 8'h18;
    localparam logic [AW-1:0] ADDR_STAT  = 8'h1C;

    // ==========================================================
    // fields
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_OP_W    = 4;
    localparam int CMD_IMM_LSB = 8;
    localparam int IMM_W       = 8;
    localparam int FLAG_C      = 0;
    localparam int FLAG_Z      = 1;
    localparam int FLAG_N      = 2;
    localparam int STAT_BUSY   = 0;
    localparam int STAT_ARMED  = 1;

    // ==========================================================
    // command codes
    localparam logic [CMD_OP_W-1:0] OP_OTHER   = 4'h0;
    localparam logic [CMD_OP_W-1:0] OP_MULU    = 4'h1;
    localparam logic [CMD_OP_W-1:0] OP_MULX    = 4'h2;
    localparam logic [CMD_OP_W-1:0] OP_ROL     = 4'h3;
    localparam logic [CMD_OP_W-1:0] OP_ROR     = 4'h4;
    localparam logic [CMD_OP_W-1:0] OP_RPT_IMM = 4'h5;
    localparam logic [CMD_OP_W-1:0] OP_RPT_MEM = 4'h6;

    // ==========================================================
    // timing, responses, resets
    localparam logic [2:0]        CYC_RPT_MEM = 3'h4;
    localparam logic [1:0]        RESP_OKAY   = 2'h0;
    localparam logic [1:0]        RESP_SLVERR = 2'h2;
    localparam logic [DW-1:0]     RST_WORD    = 32'h00000000;
    localparam logic [REPEAT_COUNTER_W-1:0] RST_REPEAT_COUNTER    = 16'h0000;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
    } mru_flags_t;

    typedef struct packed {
        logic [DW-1:0] acc;
        mru_flags_t    flags;
    } mru_rot_t;
endpackage

// ### rtl/mru_rotate.sv
// Purpose: one-bit rotate of the accumulator through carry
// Assumes: purely combinational, used once per execution cycle
// Notes:   n and z are taken from the rotated value
`timescale 1ns/1ns
module mru_rotate
    import mru_pkg::*;
(
    input  wire logic [DW-1:0]  acc,
    input  wire logic           cin,
    input  wire logic           dir_left,
    output mru_pkg::mru_rot_t   res
);
    always_comb
    begin
        if (dir_left)
        begin
            res.acc     = {acc[DW-2:0], cin};
            res.flags.c = acc[DW-1];
        end
        else
        begin
            res.acc     = {cin, acc[DW-1:1]};
            res.flags.c = acc[0];
        end
        res.flags.n = res.acc[DW-1];
        res.flags.z = (res.acc == RST_WORD);
    end
endmodule

// ### rtl/mru_mulhi.sv
// Purpose: upper half of a 32 x 32 product
// Assumes: second operand is always unsigned
// Notes:   mixed selects a signed first operand
`timescale 1ns/1ns
module mru_mulhi
    import mru_pkg::*;
(
    input  wire logic [DW-1:0] xt,
    input  wire logic [DW-1:0] opnd,
    input  wire logic          mixed,
    output logic      [DW-1:0] hi
);
    logic signed [DW:0]     a;
    logic signed [DW:0]     b;
    logic signed [2*DW+1:0] prod;

    always_comb
    begin
        a    = {mixed & xt[DW-1], xt};
        b    = {1'b0, opnd};
        prod = a * b;
        hi   = prod[2*DW-1:DW];
    end
endmodule

// ### rtl/mru_top.sv
// Purpose: multiply-high, rotate-through-carry and repeat execution unit
// Assumes: commands arrive as writes to the command register over AXI4-Lite
// Notes:   write channels stall while a multicycle sequence runs
`timescale 1ns/1ns
module mru_top
    import mru_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    input  wire logic [mru_pkg::AW-1:0] s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [mru_pkg::DW-1:0] s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [mru_pkg::AW-1:0] s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [mru_pkg::DW-1:0]    s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT} mru_state_t;

    mru_state_t        state;
    mru_state_t        next_state;
    logic [DW-1:0]     acc;
    logic [DW-1:0]     next_acc;
    logic [DW-1:0]     xt;
    logic [DW-1:0]     next_xt;
    logic [DW-1:0]     p;
    logic [DW-1:0]     next_p;
    logic [DW-1:0]     opnd;
    logic [DW-1:0]     next_opnd;
    mru_flags_t        flags;
    mru_flags_t        next_flags;
    logic [REPEAT_COUNTER_W-1:0] repeat_counter;
    logic [REPEAT_COUNTER_W-1:0] next_repeat_counter;
    logic              armed;
    logic              next_armed;
    logic              rot_left;
    logic              next_rot_left;
    logic [2:0]        wait_cnt;
    logic [2:0]        next_wait_cnt;
    logic              next_awready;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_arready;
    logic              next_rvalid;
    logic [DW-1:0]     next_rdata;
    logic [1:0]        next_rresp;

    logic              wr_fire;
    logic              rd_fire;
    logic              busy;
    logic [CMD_OP_W-1:0] cmd_op;
    logic              rot_step;
    logic              rot_dir;
    logic [DW-1:0]     mul_hi;
    mru_rot_t          rot;

    // ==========================================================
    // address decode and byte lanes
    function automatic logic reg_known(input logic [AW-1:0] a);
        reg_known = (a == ADDR_CMD) || (a == ADDR_ACC) || (a == ADDR_XT) ||
                    (a == ADDR_P) || (a == ADDR_OPND) || (a == ADDR_FLAGS) ||
                    (a == ADDR_REPEAT_COUNTER) || (a == ADDR_STAT);
    endfunction

    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
                                           input logic [DW-1:0] d,
                                           input logic [3:0]    strb);
        merge = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                merge[8*i +: 8] = d[8*i +: 8];
        end
    endfunction

    assign wr_fire  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign rd_fire  = s_axi_arvalid && s_axi_arready;
    assign busy     = (state != ST_IDLE);
    assign cmd_op   = s_axi_wdata[CMD_OP_LSB +: CMD_OP_W];
    assign rot_step = (state == ST_EXEC) ||
                      (wr_fire && s_axi_awaddr == ADDR_CMD &&
                       (cmd_op == OP_ROL || cmd_op == OP_ROR));
    assign rot_dir  = (state == ST_EXEC) ? rot_left : (cmd_op == OP_ROL);

    mru_mulhi u_mul (
        .xt    (xt),
        .opnd  (opnd),
        .mixed (cmd_op == OP_MULX),
        .hi    (mul_hi)
    );

    mru_rotate u_rot (
        .acc      (acc),
        .cin      (flags.c),
        .dir_left (rot_dir),
        .res      (rot)
    );

    // ==========================================================
    // next state
    always_comb
    begin
        next_state    = state;
        next_acc      = acc;
        next_xt       = xt;
        next_p        = p;
        next_opnd     = opnd;
        next_flags    = flags;
        next_repeat_counter     = repeat_counter;
        next_armed    = armed;
        next_rot_left = rot_left;
        next_wait_cnt = wait_cnt;
        next_bvalid   = s_axi_bvalid && !s_axi_bready;
        next_bresp    = s_axi_bresp;
        // write channels only open while idle, so a sequence cannot be broken
        next_awready  = !s_axi_awready && s_axi_awvalid && s_axi_wvalid &&
                        !s_axi_bvalid && !busy;
        next_arready  = !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
        next_rvalid   = s_axi_rvalid && !s_axi_rready;
        next_rdata    = s_axi_rdata;
        next_rresp    = s_axi_rresp;
        if (rd_fire)
        begin
            next_rvalid = 1'b1;
            next_rresp  = reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                ADDR_ACC:   next_rdata = acc;
                ADDR_XT:    next_rdata = xt;
                ADDR_P:     next_rdata = p;
                ADDR_OPND:  next_rdata = opnd;
                ADDR_FLAGS: next_rdata = {29'h0, flags};
                ADDR_REPEAT_COUNTER:  next_rdata = {16'h0, repeat_counter};
                ADDR_STAT:  next_rdata = {30'h0, armed, busy};
                default:    next_rdata = RST_WORD;
            endcase
        end
        case (state)
            ST_IDLE:
            begin
                if (wr_fire)
                begin
                    next_bvalid = 1'b1;
                    next_bresp  = reg_known(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
                    case (s_axi_awaddr)
                        ADDR_ACC:   next_acc = merge(acc, s_axi_wdata, s_axi_wstrb);
                        ADDR_XT:    next_xt = merge(xt, s_axi_wdata, s_axi_wstrb);
                        ADDR_P:     next_p = merge(p, s_axi_wdata, s_axi_wstrb);
                        ADDR_OPND:  next_opnd = merge(opnd, s_axi_wdata, s_axi_wstrb);
                        ADDR_FLAGS: next_flags = s_axi_wdata[FLAG_N:FLAG_C];
                        ADDR_CMD:
                        begin
                            // any command after repeat_next disarms the counter, except a repeat command, which arms it again
                            next_armed = 1'b0;
                            if (armed)
                                next_repeat_counter = RST_REPEAT_COUNTER;
                            case (cmd_op)
                                OP_MULU, OP_MULX:
                                    next_p = mul_hi;
                                OP_ROL, OP_ROR:
                                begin
                                    next_acc      = rot.acc;
                                    next_flags    = rot.flags;
                                    next_rot_left = (cmd_op == OP_ROL);
                                    if (armed)
                                        next_repeat_counter = repeat_counter;
                                    if (armed && repeat_counter != RST_REPEAT_COUNTER)
                                        next_state = ST_EXEC;
                                end
                                OP_RPT_IMM:
                                begin
                                    next_repeat_counter  = {8'h0, s_axi_wdata[CMD_IMM_LSB +: IMM_W]};
                                    next_armed = 1'b1;
                                end
                                OP_RPT_MEM:
                                begin
                                    next_repeat_counter     = opnd[REPEAT_COUNTER_W-1:0];
                                    next_wait_cnt = CYC_RPT_MEM - 3'h2;
                                    next_state    = ST_WAIT;
                                end
                                default:
                                    next_state = ST_IDLE;
                            endcase
                        end
                        default:
                            next_state = ST_IDLE;
                    endcase
                end
            end
            ST_EXEC:
            begin
                // each cycle is one more iteration; flags follow the latest
                next_acc   = rot.acc;
                next_flags = rot.flags;
                next_repeat_counter  = repeat_counter - 16'h1;
                if (repeat_counter == 16'h1)
                    next_state = ST_IDLE;
            end
            ST_WAIT:
            begin
                next_wait_cnt = wait_cnt - 3'h1;
                if (wait_cnt == 3'h0)
                begin
                    next_armed = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state         <= ST_IDLE;
            acc           <= RST_WORD;
            xt            <= RST_WORD;
            p             <= RST_WORD;
            opnd          <= RST_WORD;
            flags         <= '0;
            repeat_counter          <= RST_REPEAT_COUNTER;
            armed         <= 1'b0;
            rot_left      <= 1'b0;
            wait_cnt      <= 3'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= RST_WORD;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            state         <= next_state;
            acc           <= next_acc;
            xt            <= next_xt;
            p             <= next_p;
            opnd          <= next_opnd;
            flags         <= next_flags;
            repeat_counter          <= next_repeat_counter;
            armed         <= next_armed;
            rot_left      <= next_rot_left;
            wait_cnt      <= next_wait_cnt;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_awready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // ==========================================================
    // checks
    logic          cmd_fire;
    logic [DW-1:0] ref_mulu;
    logic [DW-1:0] ref_mulx;
    logic [2*DW-1:0] pu;
    logic signed [2*DW-1:0] px;

    assign cmd_fire = wr_fire && s_axi_awaddr == ADDR_CMD;
    assign pu       = {32'h0, xt} * {32'h0, opnd};
    assign px       = $signed({{32{xt[DW-1]}}, xt}) * $signed({32'h0, opnd});
    assign ref_mulu = pu[2*DW-1:DW];
    assign ref_mulx = px[2*DW-1:DW];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_mulu;
        cmd_fire && cmd_op == OP_MULU |=> p == $past(ref_mulu);
    endproperty
    a_mulu: assert property (p_mulu) else $error("unsigned high product wrong");

    property p_mulx;
        cmd_fire && cmd_op == OP_MULX |=> p == $past(ref_mulx);
    endproperty
    a_mulx: assert property (p_mulx) else $error("mixed high product wrong");

    property p_rpt_clear;
        cmd_fire && armed && (cmd_op == OP_MULU || cmd_op == OP_OTHER)
            |=> repeat_counter == 16'h0 && !armed && !busy;
    endproperty
    a_rpt_clear: assert property (p_rpt_clear) else $error("counter not cleared");

    property p_rol;
        rot_step && rot_dir |=> acc == {$past(acc[DW-2:0]), $past(flags.c)}
                                && flags.c == $past(acc[DW-1]);
    endproperty
    a_rol: assert property (p_rol) else $error("rotate left wrong");

    property p_ror;
        rot_step && !rot_dir |=> acc == {$past(flags.c), $past(acc[DW-1:1])}
                                 && flags.c == $past(acc[0]);
    endproperty
    a_ror: assert property (p_ror) else $error("rotate right wrong");

    property p_nz;
        rot_step |=> flags.n == acc[DW-1] && flags.z == (acc == 32'h0);
    endproperty
    a_nz: assert property (p_nz) else $error("n or z flag wrong");

    property p_rep_len;
        cmd_fire && (cmd_op == OP_ROL || cmd_op == OP_ROR) && armed && repeat_counter == 16'h3
            |=> busy [*3] ##1 !busy;
    endproperty
    a_rep_len: assert property (p_rep_len) else $error("repeat length wrong");

    property p_lock;
        busy |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_lock: assert property (p_lock) else $error("write taken mid sequence");

    property p_mul_flags;
        cmd_fire && (cmd_op == OP_MULU || cmd_op == OP_MULX) |=> $stable(flags) && !busy;
    endproperty
    a_mul_flags: assert property (p_mul_flags) else $error("multiply touched flags");

    property p_rpt_imm;
        cmd_fire && cmd_op == OP_RPT_IMM
            |=> !busy && armed && repeat_counter == {8'h0, $past(s_axi_wdata[15:8])};
    endproperty
    a_rpt_imm: assert property (p_rpt_imm) else $error("immediate repeat wrong");

    property p_rpt_mem;
        cmd_fire && cmd_op == OP_RPT_MEM |=> (busy && $stable(flags)) [*3] ##1 (!busy && armed);
    endproperty
    a_rpt_mem: assert property (p_rpt_mem) else $error("operand repeat timing wrong");
endmodule

// ### test/mru_host.sv
// Purpose: bus master model for the decoder and operand fetch side
// Assumes: one transfer at a time, signals changed just after rising edges
// Notes:   waits have no bound here; the bench watchdog ends a hang
`timescale 1ns/1ns
module mru_host
    import mru_pkg::*;
(
    input  wire logic                   mclk,
    output logic [mru_pkg::AW-1:0]      s_axi_awaddr,
    output logic                        s_axi_awvalid,
    input  wire logic                   s_axi_awready,
    output logic [mru_pkg::DW-1:0]      s_axi_wdata,
    output logic [3:0]                  s_axi_wstrb,
    output logic                        s_axi_wvalid,
    input  wire logic                   s_axi_wready,
    input  wire logic [1:0]             s_axi_bresp,
    input  wire logic                   s_axi_bvalid,
    output logic                        s_axi_bready,
    output logic [mru_pkg::AW-1:0]      s_axi_araddr,
    output logic                        s_axi_arvalid,
    input  wire logic                   s_axi_arready,
    input  wire logic [mru_pkg::DW-1:0] s_axi_rdata,
    input  wire logic [1:0]             s_axi_rresp,
    input  wire logic                   s_axi_rvalid,
    output logic                        s_axi_rready
);
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    end

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        // the iff test sees the values that stand at the edge, before the slave updates
        @(posedge mclk iff (s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
        // released lines show a changed value, not the last one
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        s_axi_awaddr  <= ~a;
        s_axi_wdata   <= ~d;
        @(posedge mclk iff (s_axi_bvalid === 1'b1));
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        @(posedge mclk iff (s_axi_arready === 1'b1));
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
        @(posedge mclk iff (s_axi_rvalid === 1'b1));
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// ### test/multiply_rotate_repeat_unit_tb.sv
// Purpose: self-checking bench for the multiply/rotate/repeat unit
// Assumes: commands and operands reach the unit through register writes
// Notes:   expected values come from a reference rotate and plain products
`timescale 1ns/1ns
module multiply_rotate_repeat_unit_tb;
    import mru_pkg::*;
    logic          mclk = 1'b0;
    logic          sys_rst = 1'b1;
    logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DW-1:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0]    s_axi_wstrb;
    logic [1:0]    s_axi_bresp, s_axi_rresp, rsp;
    logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic          s_axi_rvalid, s_axi_rready;
    int            err_total = 0;
    int            n_tests = 0;

    always #10 mclk = ~mclk;

    mru_top dut_u (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    mru_host host_u (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // ==========================================================
    // helpers
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        host_u.wr(a, d, rsp);
    endtask

    task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        host_u.rd(a, rv, rsp);
        chk(rv, exp);
    endtask

    function automatic logic [DW-1:0] rpt_cmd(input logic [7:0] n);
        return {16'h0000, n, 4'h0, OP_RPT_IMM};
    endfunction

    // state is {n, z, c, acc}
    function automatic logic [34:0] rot(input logic [34:0] s, input logic left);
        logic [DW-1:0] a;
        a = left ? {s[30:0], s[32]} : {s[32], s[31:1]};
        return {a[31], a == 32'h00000000, left ? s[31] : s[0], a};
    endfunction

    // ==========================================================
    // scenarios
    task automatic t_reset;
        for (int i = 0; i < 8; i++)
            rdc(8'(i * 4), 32'h00000000);
    endtask

    task automatic t_mul(input logic [DW-1:0] x, input logic [DW-1:0] o);
        logic [63:0] pu, px;
        pu = {32'h00000000, x} * {32'h00000000, o};
        px = $signed({{32{x[31]}}, x}) * $signed({32'h00000000, o});
        wr(ADDR_XT, x);
        wr(ADDR_OPND, o);
        wr(ADDR_FLAGS, 32'h00000005);
        wr(ADDR_CMD, rpt_cmd(8'hFF));
        rdc(ADDR_REPEAT_COUNTER, 32'h000000FF);
        wr(ADDR_CMD, rpt_cmd(8'h09));
        rdc(ADDR_REPEAT_COUNTER, 32'h00000009);
        wr(ADDR_CMD, {28'h0000000, OP_MULU});
        rdc(ADDR_P, pu[63:32]);
        rdc(ADDR_REPEAT_COUNTER, 32'h00000000);
        rdc(ADDR_STAT, 32'h00000000);
        wr(ADDR_CMD, {28'h0000000, OP_MULX});
        rdc(ADDR_P, px[63:32]);
        rdc(ADDR_FLAGS, 32'h00000005);
    endtask

    // mode 0 plain, 1 immediate count, 2 count from the operand register
    task automatic t_rot(input logic left, input int mode, input int n,
                         input logic [DW-1:0] a0, input logic [2:0] f0);
        logic [34:0] s;
        int          k;
        s = {f0, a0};
        wr(ADDR_ACC, a0);
        wr(ADDR_FLAGS, {29'h00000000, f0});
        if (mode == 1)
            wr(ADDR_CMD, rpt_cmd(n[7:0]));
        if (mode == 2)
        begin
            wr(ADDR_OPND, 32'(n));
            wr(ADDR_CMD, {28'h0000000, OP_RPT_MEM});
        end
        repeat (n + 1) s = rot(s, left);
        wr(ADDR_CMD, {28'h0000000, left ? OP_ROL : OP_ROR});
        if (n > 20)
        begin
            host_u.rd(ADDR_STAT, rv, rsp);
            chk(rv & 32'h00000001, 32'h00000001);
            // held back until the sequence ends, so it lands on the final flags
            wr(ADDR_FLAGS, 32'h00000007);
            s[34:32] = 3'h7;
        end
        k = 0;
        do
        begin
            host_u.rd(ADDR_STAT, rv, rsp);
            k++;
        end
        while (rv[STAT_BUSY] !== 1'b0 && k < 400);
        chk(rv, 32'h00000000);
        rdc(ADDR_ACC, s[31:0]);
        rdc(ADDR_FLAGS, {29'h00000000, s[34:32]});
        rdc(ADDR_REPEAT_COUNTER, 32'h00000000);
    endtask

    task automatic t_bad;
        host_u.wr(8'h20, 32'hFFFFFFFF, rsp);
        chk({30'h00000000, rsp}, {30'h00000000, RESP_SLVERR});
        host_u.rd(8'h20, rv, rsp);
        chk({30'h00000000, rsp}, {30'h00000000, RESP_SLVERR});
        chk(rv, 32'h00000000);
        wr(ADDR_REPEAT_COUNTER, 32'h00000012);
        rdc(ADDR_REPEAT_COUNTER, 32'h00000000);
    endtask

    // ==========================================================
    // sequence and watchdog
    initial
    begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset;
        t_mul(32'hFFFFFFFF, 32'hFFFFFFFF);
        t_mul(32'h80000000, 32'hFFFFFFFF);
        t_mul(32'h7FFFFFFF, 32'h80000001);
        t_rot(1'b1, 0, 0, 32'h80000001, 3'h0);
        t_rot(1'b0, 0, 0, 32'h00000001, 3'h0);
        t_rot(1'b1, 1, 3, 32'hA5A5A5A5, 3'h1);
        t_rot(1'b1, 1, 0, 32'hFFFFFFFF, 3'h0);
        t_rot(1'b0, 1, 255, 32'h12345678, 3'h4);
        t_rot(1'b0, 2, 300, 32'h0000F00F, 3'h2);
        t_bad;
        give_verdict;
    end

    initial
    begin
        repeat (60000) @(posedge mclk);
        err_total++;
        give_verdict;
    end
endmodule
